// file: hw/eip_pkg.sv
`default_nettype none

package eip_pkg;

	// Bus geometry.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned REG_W  = 16;
	localparam int unsigned EXT_N  = 5;

	// Register byte offsets, one aligned word each.
	localparam logic [11:0] OFS_CTRL_TWO   = 12'h000;
	localparam logic [11:0] OFS_FLAG_ZERO  = 12'h004;
	localparam logic [11:0] OFS_EVT_STATUS = 12'h008;
	localparam logic [11:0] OFS_EVT_MASK   = 12'h00c;

	// Bit positions in the flag, event status and event mask registers.
	localparam int unsigned BIT_EXT0       = 0;
	localparam int unsigned BIT_CAPTURE1   = 1;
	localparam int unsigned BIT_COMPARE1   = 2;
	localparam int unsigned BIT_TIMER1     = 3;
	localparam int unsigned BIT_CAPTURE2   = 5;
	localparam int unsigned BIT_COMPARE2   = 6;
	localparam int unsigned BIT_TIMER2     = 7;
	localparam int unsigned BIT_TIMER3     = 8;
	localparam int unsigned BIT_SYNC_FAULT = 9;
	localparam int unsigned BIT_SYNC_EVENT = 10;
	localparam int unsigned BIT_SERIAL_RX  = 11;
	localparam int unsigned BIT_SERIAL_TX  = 12;
	localparam int unsigned BIT_ADC_DONE   = 13;

	// Polarity bits of the second control register sit at bits 4 down to 0.
	localparam int unsigned BIT_EXT1_POL = 1;
	localparam int unsigned BIT_EXT2_POL = 2;

	// Implemented-bit masks and reset values.
	localparam logic [15:0] FLAG_IMPL_MASK = 16'h3fef;
	localparam logic [15:0] CTRL_IMPL_MASK = 16'h001f;
	localparam logic [15:0] FLAG_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] EVT_RESET      = 16'h0000;
	localparam logic [15:0] MASK_RESET     = 16'h0000;

	// Polarity encoding: one selects the falling edge.
	localparam logic POL_FALLING = 1'b1;

endpackage : eip_pkg

`default_nettype wire

// file: hw/eip_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module eip_edge_detect
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic pin,
	input  wire logic falling_sel,
	output logic      edge_pulse
);

	logic prev_ff;
	logic primed_ff;

	// The first enabled cycle after reset only samples the pin, so a pin
	// that is already high does not fake a rising edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff   <= 1'b0;
			primed_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_ff   <= pin;
			primed_ff <= 1'b1;
		end
	end

	always_comb
	begin
		if (falling_sel == eip_pkg::POL_FALLING)
			edge_pulse = clk_en & primed_ff & prev_ff & ~pin;
		else
			edge_pulse = clk_en & primed_ff & ~prev_ff & pin;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_falling_edge_fires: assert property (
		clk_en && primed_ff && falling_sel && prev_ff && !pin |-> edge_pulse)
		else $error("falling edge missed while falling polarity selected");

	chk_rising_edge_fires: assert property (
		clk_en && primed_ff && !falling_sel && !prev_ff && pin |-> edge_pulse)
		else $error("rising edge missed while rising polarity selected");

	chk_wrong_edge_quiet: assert property (
		edge_pulse |-> (falling_sel ? (prev_ff && !pin) : (!prev_ff && pin)))
		else $error("edge pulse on the unselected edge");

endmodule : eip_edge_detect

`default_nettype wire

// file: hw/eip_irq_bank.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module eip_irq_bank
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          clk_en,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [eip_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [eip_pkg::DATA_W-1:0]    pwdata,
	input  wire logic [eip_pkg::STRB_W-1:0]    pstrb,
	output logic [eip_pkg::DATA_W-1:0]         prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [eip_pkg::EXT_N-1:0]     ext_pin,
	input  wire logic                          adc_done_req,
	input  wire logic                          serial1_tx_req,
	input  wire logic                          serial1_rx_req,
	input  wire logic                          sync1_event_req,
	input  wire logic                          sync1_fault_req,
	input  wire logic                          timer_three_req,
	input  wire logic                          timer_two_req,
	input  wire logic                          compare_two_req,
	input  wire logic                          capture_two_req,
	input  wire logic                          timer_one_req,
	input  wire logic                          compare_one_req,
	input  wire logic                          capture_one_req,
	output logic [eip_pkg::EXT_N-1:0]          ext_edge_pulse,
	output logic                               irq
);

	logic [eip_pkg::REG_W-1:0]  ctrl_ff;
	logic [eip_pkg::REG_W-1:0]  flag_ff;
	logic [eip_pkg::REG_W-1:0]  evt_ff;
	logic [eip_pkg::REG_W-1:0]  mask_ff;
	logic [eip_pkg::REG_W-1:0]  nxt_ctrl;
	logic [eip_pkg::REG_W-1:0]  nxt_flag;
	logic [eip_pkg::REG_W-1:0]  nxt_evt;
	logic [eip_pkg::REG_W-1:0]  nxt_mask;
	logic [eip_pkg::REG_W-1:0]  hw_set;
	logic [eip_pkg::DATA_W-1:0] prdata_ff;
	logic [eip_pkg::DATA_W-1:0] nxt_prdata;
	logic                       pslverr_ff;
	logic                       held_ff;
	logic                       setup_phase;
	logic                       acc_done;
	logic                       wr_ctrl;
	logic                       wr_flag;
	logic                       wr_mask;
	logic                       rd_evt;

	function automatic logic reg_hit(
		input logic [eip_pkg::ADDR_W-1:0] addr,
		input logic [eip_pkg::ADDR_W-1:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// Only the two low byte lanes carry register bits.
	function automatic logic [eip_pkg::REG_W-1:0] merge_lanes(
		input logic [eip_pkg::REG_W-1:0]  old_val,
		input logic [eip_pkg::DATA_W-1:0] wdata,
		input logic [eip_pkg::STRB_W-1:0] strb,
		input logic [eip_pkg::REG_W-1:0]  impl
	);
		logic [eip_pkg::REG_W-1:0] res;
		res = old_val;
		if (strb[0])
			res[7:0] = wdata[7:0];
		if (strb[1])
			res[15:8] = wdata[15:8];
		merge_lanes = res & impl;
	endfunction : merge_lanes

	genvar gi;
	generate
		for (gi = 0; gi < eip_pkg::EXT_N; gi++)
		begin : g_ext
			eip_edge_detect u_edge
			(
				.pclk        (pclk),
				.presetn     (presetn),
				.clk_en      (clk_en),
				.pin         (ext_pin[gi]),
				.falling_sel (ctrl_ff[gi]),
				.edge_pulse  (ext_edge_pulse[gi])
			);
		end
	endgenerate

	// APB: read data is captured in the setup cycle, so the access phase
	// completes in its first cycle unless the clock enable is low.
	assign setup_phase = psel & ~penable;
	assign pready      = psel & penable & clk_en & held_ff;
	assign acc_done    = pready;
	assign pslverr     = pready & pslverr_ff;
	assign prdata      = prdata_ff;

	assign wr_ctrl = acc_done & pwrite & reg_hit(paddr, eip_pkg::OFS_CTRL_TWO);
	assign wr_flag = acc_done & pwrite & reg_hit(paddr, eip_pkg::OFS_FLAG_ZERO);
	assign wr_mask = acc_done & pwrite & reg_hit(paddr, eip_pkg::OFS_EVT_MASK);
	assign rd_evt  = acc_done & ~pwrite & reg_hit(paddr, eip_pkg::OFS_EVT_STATUS);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			held_ff <= 1'b0;
		else if (clk_en)
		begin
			if (setup_phase)
				held_ff <= 1'b1;
			else if (acc_done)
				held_ff <= 1'b0;
		end
	end

	always_comb
	begin
		nxt_prdata = '0;
		if (reg_hit(paddr, eip_pkg::OFS_CTRL_TWO))
			nxt_prdata[eip_pkg::REG_W-1:0] = ctrl_ff;
		else if (reg_hit(paddr, eip_pkg::OFS_FLAG_ZERO))
			nxt_prdata[eip_pkg::REG_W-1:0] = flag_ff;
		else if (reg_hit(paddr, eip_pkg::OFS_EVT_STATUS))
			nxt_prdata[eip_pkg::REG_W-1:0] = evt_ff;
		else if (reg_hit(paddr, eip_pkg::OFS_EVT_MASK))
			nxt_prdata[eip_pkg::REG_W-1:0] = mask_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end
		else if (clk_en && setup_phase)
		begin
			prdata_ff  <= pwrite ? '0 : nxt_prdata;
			pslverr_ff <= ~(reg_hit(paddr, eip_pkg::OFS_CTRL_TWO)
				| reg_hit(paddr, eip_pkg::OFS_FLAG_ZERO)
				| reg_hit(paddr, eip_pkg::OFS_EVT_STATUS)
				| reg_hit(paddr, eip_pkg::OFS_EVT_MASK));
		end
	end

	always_comb
	begin
		hw_set = '0;
		hw_set[eip_pkg::BIT_EXT0]       = ext_edge_pulse[0];
		hw_set[eip_pkg::BIT_CAPTURE1]   = capture_one_req;
		hw_set[eip_pkg::BIT_COMPARE1]   = compare_one_req;
		hw_set[eip_pkg::BIT_TIMER1]     = timer_one_req;
		hw_set[eip_pkg::BIT_CAPTURE2]   = capture_two_req;
		hw_set[eip_pkg::BIT_COMPARE2]   = compare_two_req;
		hw_set[eip_pkg::BIT_TIMER2]     = timer_two_req;
		hw_set[eip_pkg::BIT_TIMER3]     = timer_three_req;
		hw_set[eip_pkg::BIT_SYNC_FAULT] = sync1_fault_req;
		hw_set[eip_pkg::BIT_SYNC_EVENT] = sync1_event_req;
		hw_set[eip_pkg::BIT_SERIAL_RX]  = serial1_rx_req;
		hw_set[eip_pkg::BIT_SERIAL_TX]  = serial1_tx_req;
		hw_set[eip_pkg::BIT_ADC_DONE]   = adc_done_req;
	end

	assign nxt_ctrl = wr_ctrl ? merge_lanes(ctrl_ff, pwdata, pstrb, eip_pkg::CTRL_IMPL_MASK)
		: ctrl_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= eip_pkg::CTRL_RESET;
		else if (clk_en)
			ctrl_ff <= nxt_ctrl;
	end

	// The hardware set is ORed in after the software write, so a request in
	// the cycle of a clearing write is never lost.
	always_comb
	begin
		nxt_flag = flag_ff;
		if (wr_flag)
			nxt_flag = merge_lanes(flag_ff, pwdata, pstrb, eip_pkg::FLAG_IMPL_MASK);
		nxt_flag = (nxt_flag | hw_set) & eip_pkg::FLAG_IMPL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_ff <= eip_pkg::FLAG_RESET;
		else if (clk_en)
			flag_ff <= nxt_flag;
	end

	// A status read clears only the bits it returned, so an event landing
	// between the setup capture and the access edge stays pending.
	always_comb
	begin
		nxt_evt = evt_ff;
		if (rd_evt)
			nxt_evt = evt_ff & ~prdata_ff[eip_pkg::REG_W-1:0];
		nxt_evt = (nxt_evt | hw_set) & eip_pkg::FLAG_IMPL_MASK;
	end

	assign nxt_mask = wr_mask ? merge_lanes(mask_ff, pwdata, pstrb, eip_pkg::FLAG_IMPL_MASK)
		: mask_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			evt_ff  <= eip_pkg::EVT_RESET;
			mask_ff <= eip_pkg::MASK_RESET;
		end
		else if (clk_en)
		begin
			evt_ff  <= nxt_evt;
			mask_ff <= nxt_mask;
		end
	end

	assign irq = |(evt_ff & mask_ff);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_flag_write_zero(int unsigned b);
		wr_flag && pstrb[b / 8] && !pwdata[b];
	endsequence

	sequence s_status_read;
		psel && !penable && !pwrite && clk_en
			&& paddr == eip_pkg::OFS_EVT_STATUS
		##1 acc_done;
	endsequence

	sequence s_setup_access;
		psel && !penable && clk_en
		##1 psel && penable && clk_en;
	endsequence

	chk_reset_flags_zero: assert property (
		$rose(presetn) |-> flag_ff == eip_pkg::FLAG_RESET)
		else $error("flags not zero after reset");

	chk_flag_hold: assert property (
		clk_en && !wr_flag && flag_ff[eip_pkg::BIT_TIMER3] |=> flag_ff[eip_pkg::BIT_TIMER3])
		else $error("set flag dropped without a write");

	chk_set_beats_clear: assert property (
		s_flag_write_zero(eip_pkg::BIT_TIMER2) and (clk_en && timer_two_req)
		|=> flag_ff[eip_pkg::BIT_TIMER2])
		else $error("hardware set lost to a software clear");

	chk_sw_clear_works: assert property (
		s_flag_write_zero(eip_pkg::BIT_SERIAL_TX) and (clk_en && !serial1_tx_req)
		|=> !flag_ff[eip_pkg::BIT_SERIAL_TX])
		else $error("writing zero did not clear the flag");

	chk_timer2_position: assert property (
		clk_en && timer_two_req |=> flag_ff[eip_pkg::BIT_TIMER2] ##1 1'b1)
		else $error("timer 2 request not at bit 7");

	chk_timer1_position: assert property (
		clk_en && timer_one_req |=> flag_ff[eip_pkg::BIT_TIMER1])
		else $error("timer 1 request not at bit 3");

	chk_ext0_position: assert property (
		ext_edge_pulse[0] |=> flag_ff[eip_pkg::BIT_EXT0] && evt_ff[eip_pkg::BIT_EXT0])
		else $error("external 0 edge not at bit 0");

	chk_capture1_position: assert property (
		clk_en && capture_one_req |=> flag_ff[eip_pkg::BIT_CAPTURE1])
		else $error("capture 1 request not at bit 1");

	chk_rx_position: assert property (
		clk_en && serial1_rx_req |=> flag_ff[eip_pkg::BIT_SERIAL_RX])
		else $error("receive request not at bit 11");

	chk_reserved_zero: assert property (
		s_status_read or (acc_done && !pwrite && paddr == eip_pkg::OFS_FLAG_ZERO)
		|-> prdata[15:14] == 2'h0 && prdata[4] == 1'b0)
		else $error("reserved flag bits read nonzero");

	chk_polarity_bits: assert property (
		wr_ctrl && pstrb[0]
		|=> ctrl_ff[eip_pkg::BIT_EXT2_POL] == $past(pwdata[2])
			&& ctrl_ff[eip_pkg::BIT_EXT1_POL] == $past(pwdata[1]))
		else $error("polarity bits not at bits 2 and 1");

	chk_ext1_falls: assert property (
		ctrl_ff[eip_pkg::BIT_EXT1_POL] && ext_edge_pulse[1] && $past(clk_en)
		|-> $past(ext_pin[1]) && !ext_pin[1])
		else $error("external 1 fired off its falling edge");

	chk_ready_first_cycle: assert property (
		s_setup_access
		|-> pready)
		else $error("access phase not ready in its first enabled cycle");

	chk_unmapped_error: assert property (
		psel && !penable && clk_en && paddr > eip_pkg::OFS_EVT_MASK
		##1 pready |-> pslverr)
		else $error("unmapped access answered without an error");

	chk_enable_freezes: assert property (
		!clk_en
		|=> $stable(flag_ff) && $stable(evt_ff) && $stable(ctrl_ff) && $stable(mask_ff))
		else $error("register state moved while the clock enable was low");

	// Only a quiet read is checked, since a new event may legally re-set a returned bit.
	chk_read_clears_events: assert property (
		s_status_read ##0 (hw_set == '0)
		|=> (evt_ff & $past(prdata_ff[eip_pkg::REG_W-1:0])) == '0)
		else $error("status read left a returned event pending");

	chk_fault_position: assert property (
		clk_en && sync1_fault_req
		|=> flag_ff[eip_pkg::BIT_SYNC_FAULT] && evt_ff[eip_pkg::BIT_SYNC_FAULT])
		else $error("fault request not at bit 9");

	chk_adc_position: assert property (
		clk_en && adc_done_req
		|=> flag_ff[eip_pkg::BIT_ADC_DONE] && evt_ff[eip_pkg::BIT_ADC_DONE])
		else $error("conversion request not at bit 13");

	chk_tx_position: assert property (
		clk_en && serial1_tx_req
		|=> flag_ff[eip_pkg::BIT_SERIAL_TX] && evt_ff[eip_pkg::BIT_SERIAL_TX])
		else $error("transmit request not at bit 12");

endmodule : eip_irq_bank

`default_nettype wire

// file: verification/eip_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the peripherals and the external pins.
// Every change lands just after a rising edge, so the block samples a settled level.
module eip_periph_model
(
	input  wire logic        pclk,
	output logic      [11:0] req,
	output logic      [4:0]  pin
);
	initial
	begin
		req = 12'h000;
		pin = 5'h00;
	end

	task drive(input int i, input logic v);
		@(posedge pclk);
		req[i] <= v;
	endtask : drive

	task set_pin(input int i, input logic v);
		@(posedge pclk);
		pin[i] <= v;
	endtask : set_pin
endmodule : eip_periph_model

`default_nettype wire

// file: verification/test_eip_irq_bank.sv
`timescale 1ns/1ps
`default_nettype none

module test_eip_irq_bank;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [11:0] req;
	logic [4:0]  pin;
	logic [4:0]  ext_edge_pulse;
	logic        irq;
	int          errors;
	int          check_count;
	int          seed;
	int          m_ctrl;
	int          m_flag;
	int          m_evt;
	int          m_mask;
	int          pos [12] = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 3, 2, 1};
	logic [31:0] r;
	logic        clk_en;
	logic [3:0]  strb;
	int          waits;

	eip_periph_model pm (.pclk(pclk), .req(req), .pin(pin));

	eip_irq_bank uut
	(
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_pin(pin), .adc_done_req(req[0]),
		.serial1_tx_req(req[1]), .serial1_rx_req(req[2]), .sync1_event_req(req[3]),
		.sync1_fault_req(req[4]), .timer_three_req(req[5]), .timer_two_req(req[6]),
		.compare_two_req(req[7]), .capture_two_req(req[8]), .timer_one_req(req[9]),
		.compare_one_req(req[10]), .capture_one_req(req[11]),
		.ext_edge_pulse(ext_edge_pulse), .irq(irq)
	);

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task close_out;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask : chk

	// One APB transfer; the model is compared on reads and updated at the access edge.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int          n;
		logic [31:0] exp;
		n = 0;
		exp = (a == 12'h000) ? 32'(m_ctrl) : (a == 12'h004) ? 32'(m_flag) :
			(a == 12'h008) ? 32'(m_evt) : (a == 12'h00c) ? 32'(m_mask) : 32'h0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		waits = n;
		if (pready !== 1'b1)
		begin
			errors++;
			close_out;
		end
		if (!wr)
			chk(prdata, exp);
		chk({31'h0, pslverr}, {31'h0, a > 12'h00c});
		// Byte lanes that are not strobed keep the model's old contents.
		d = {16'h0, strb[1] ? d[15:8] : exp[15:8], strb[0] ? d[7:0] : exp[7:0]};
		if (wr && a == 12'h000)
			m_ctrl = d & 32'h1f;
		if (wr && a == 12'h004)
			m_flag = d & 32'h3fef;
		if (wr && a == 12'h00c)
			m_mask = d & 32'h3fef;
		if (!wr && a == 12'h008)
			m_evt = 0;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task fire(input int k);
		pm.drive(k, 1'b1);
		pm.drive(k, 1'b0);
		m_flag |= 1 << pos[k];
		m_evt |= 1 << pos[k];
	endtask : fire

	task chk_irq;
		@(posedge pclk);
		#1 chk({31'h0, irq}, {31'h0, (m_evt & m_mask) != 0});
	endtask : chk_irq

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		strb = 4'hf;
		waits = 0;
		{errors, check_count, m_ctrl, m_flag, m_evt, m_mask} = '0;
		seed = 39;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 5; k++)
			apb(1'b0, 12'(4 * k), 32'h0);
		$display("test reset done");
		for (int k = 0; k < 4; k++)
		begin
			r = $random(seed);
			apb(1'b1, 12'h000, r);
			apb(1'b0, 12'h000, 32'h0);
			apb(1'b1, 12'h004, r);
			apb(1'b0, 12'h004, 32'h0);
		end
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h010, 32'hffff);
		$display("test access done");
		for (int k = 0; k < 12; k++)
		begin
			fire(k);
			apb(1'b0, 12'h004, 32'h0);
			apb(1'b0, 12'h008, 32'h0);
			apb(1'b0, 12'h008, 32'h0);
			apb(1'b1, 12'h004, 32'h0);
			apb(1'b0, 12'h004, 32'h0);
		end
		$display("test flags done");
		for (int i = 0; i < 5; i++)
			for (int p = 0; p < 2; p++)
			begin
				apb(1'b1, 12'h000, 32'(p << i));
				pm.set_pin(i, p[0]);
				pm.set_pin(i, !p[0]);
				#1 chk({27'h0, ext_edge_pulse}, 32'(1 << i));
				pm.set_pin(i, p[0]);
				#1 chk({27'h0, ext_edge_pulse}, 32'h0);
				m_flag |= (i == 0);
				m_evt |= (i == 0);
				apb(1'b0, 12'h004, 32'h0);
				apb(1'b0, 12'h008, 32'h0);
				apb(1'b1, 12'h004, 32'h0);
			end
		$display("test edges done");
		apb(1'b1, 12'h00c, 32'h8);
		apb(1'b0, 12'h00c, 32'h0);
		fire(10);
		chk_irq;
		fire(9);
		chk_irq;
		apb(1'b1, 12'h00c, 32'h0);
		chk_irq;
		apb(1'b1, 12'h00c, 32'h8);
		chk_irq;
		apb(1'b0, 12'h008, 32'h0);
		chk_irq;
		$display("test interrupt done");
		strb <= 4'h2;
		apb(1'b1, 12'h004, 32'hffff);
		apb(1'b0, 12'h004, 32'h0);
		strb <= 4'h1;
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		strb <= 4'hf;
		// The enable drops for three access cycles while a request is raised.
		fork
			apb(1'b0, 12'h004, 32'h0);
			begin
				repeat (2) @(posedge pclk);
				clk_en <= 1'b0;
				pm.drive(9, 1'b1);
				pm.drive(9, 1'b0);
				@(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		chk(waits, 3);
		apb(1'b0, 12'h008, 32'h0);
		$display("test lanes and enable done");
		pm.drive(6, 1'b1);
		repeat (2) @(posedge pclk);
		apb(1'b1, 12'h004, 32'h0);
		pm.drive(6, 1'b0);
		m_flag |= 128;
		apb(1'b0, 12'h004, 32'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		{m_ctrl, m_flag, m_evt, m_mask} = '0;
		for (int k = 0; k < 4; k++)
			apb(1'b0, 12'(4 * k), 32'h0);
		$display("test clash and reset done");
		close_out;
	end
endmodule : test_eip_irq_bank

`default_nettype wire
